/* hw/eba_ctrl.sv */
// External bus access sequencer with acknowledge termination and time-out
`default_nettype none


module eba_ctrl #(
    parameter int TIMEOUT = eba_pkg::TIMEOUT_CYC
) (
    input  wire logic                          clk_i,
    input  wire logic                          rst_b_i,
    input  wire eba_pkg::eba_req_t             req_i,
    input  wire eba_pkg::eba_cfg_t             cfg_i,
    input  wire logic                          ack_edge_global_bit_i,
    output logic                               busy_o,
    output logic                               rsp_valid_o,
    output logic                               rsp_err_o,
    output logic [eba_pkg::DATA_W-1:0]         rsp_rdata_o,
    input  wire logic                          transfer_ack_input_i,
    input  wire logic [eba_pkg::DATA_W-1:0]    ext_data_i,
    output logic [eba_pkg::DATA_W-1:0]         ext_data_o,
    output logic                               ext_data_oe_b_o,
    output logic [eba_pkg::ADDR_W-1:0]         ext_addr_o,
    output logic [eba_pkg::NUM_CS-1:0]         ext_cs_b_o,
    output logic                               ext_rw_o,
    output logic                               ext_oe_b_o,
    output logic [3:0]                         byte_lane_enable_b_o,
    output logic                               burst_addr_load_b_o,
    output logic                               burst_clk_o
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic                       ack_s;
    logic [eba_pkg::DATA_W-1:0] data_s;

    eba_sync #(.W(1)) u_ack_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .d_i     (transfer_ack_input_i),
        .q_o     (ack_s)
    );

    // Data settles long before the strobe closes, so the sync delay is harmless
    eba_sync #(.W(eba_pkg::DATA_W)) u_data_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .d_i     (ext_data_i),
        .q_o     (data_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // State
    eba_pkg::eba_state_t st;
    eba_pkg::eba_state_t next_st;

    logic                       edge_req;
    logic                       level_req;
    logic                       ack_rise;
    logic [10:0]                blank;
    logic                       blanked;
    logic                       done;
    logic                       timed_out;
    logic [5:0]                 remain;
    logic                       second;

    // Mode decode from the incoming request
    always_comb begin
        edge_req  = (req_i.sel == eba_pkg::EDGE_SEL)
                    && (cfg_i.wait_state_count == eba_pkg::EDGE_WSC)
                    && ((cfg_i.select_assert_delay != 4'h0)
                        || (cfg_i.select_negate_delay != 4'h0))
                    && ack_edge_global_bit_i
                    && !cfg_i.sync_mode;
        level_req = cfg_i.ack_level_enable
                    && (cfg_i.wait_state_count > 6'h01)
                    && (cfg_i.select_negate_delay < 4'h3)
                    && !ack_edge_global_bit_i
                    && (req_i.sel != eba_pkg::SHARE_SEL)
                    && !cfg_i.sync_mode;
    end

    // Access progress terms
    always_comb begin
        ack_rise  = ack_s && !st.ack_d;
        blank     = 11'(eba_pkg::BLANK_MIN) + {9'h000, st.cfg.ack_blanking_time};
        blanked   = st.tick < blank;
        remain    = st.cfg.wait_state_count - st.wait_cnt;
        second    = st.req.word && st.cfg.port_width_select && !st.half;
        if (st.edge_mode) begin
            done = ack_rise;
        end else if (st.level_mode) begin
            done = (remain == 6'h00) && !blanked && ack_s;
        end else begin
            done = (remain == 6'h00);
        end
        timed_out = (st.edge_mode || st.level_mode) && !done
                    && (st.tick == 11'(TIMEOUT - 1));
    end

    always_comb begin
        next_st           = st;
        next_st.rsp_valid = 1'b0;
        next_st.lba_b     = 1'b1;
        next_st.ack_d     = ack_s;
        case (st.fsm)
            eba_pkg::S_IDLE: begin
                next_st.bclk = 1'b0;
                if (req_i.valid) begin
                    next_st.req        = req_i;
                    next_st.cfg        = cfg_i;
                    next_st.edge_mode  = edge_req;
                    next_st.level_mode = level_req;
                    next_st.half       = 1'b0;
                    next_st.addr       = req_i.addr;
                    next_st.rw         = !req_i.write;
                    next_st.dout       = req_i.wdata;
                    next_st.cnt        = 4'h0;
                    next_st.rsp_err    = 1'b0;
                    next_st.busy       = 1'b1;
                    next_st.fsm        = eba_pkg::S_LEAD;
                end
            end
            eba_pkg::S_LEAD: begin
                // Select stays negated for the assert delay
                if (st.cnt >= st.cfg.select_assert_delay) begin
                    next_st.cs_b[st.req.sel] = 1'b0;
                    next_st.tick             = 11'h000;
                    next_st.wait_cnt         = 6'h00;
                    next_st.lba_b            = !st.cfg.sync_mode;
                    next_st.dout_oe_b        = st.rw;
                    if (st.req.write || st.cfg.byte_lane_control) begin
                        next_st.eb_b = st.cfg.port_width_select ? eba_pkg::EB_HALF : eba_pkg::EB_WORD;
                    end
                    next_st.fsm = eba_pkg::S_ACCESS;
                end else begin
                    next_st.cnt = st.cnt + 4'h1;
                end
            end
            eba_pkg::S_ACCESS: begin
                next_st.tick = st.tick + 11'h001;
                // Burst clock only in synchronous mode, never faster than its floor
                if (st.cfg.sync_mode) begin
                    next_st.bclk = !st.bclk;
                end
                // Wait states advance unless, in level mode after the blanking time, a low acknowledge holds them
                if ((remain != 6'h00) && !(st.level_mode && !ack_s && !blanked)) begin
                    next_st.wait_cnt = st.wait_cnt + 6'h01;
                end
                // Read strobe window from its assert delay and, outside edge mode, its negate delay
                if (st.rw && (st.tick >= {7'h00, st.cfg.read_strobe_assert_delay})
                    && (st.edge_mode || (remain > {2'h0, st.cfg.read_strobe_negate_delay}))) begin
                    next_st.oe_b = 1'b0;
                end else begin
                    next_st.oe_b = 1'b1;
                end
                if (timed_out) begin
                    next_st.cs_b      = eba_pkg::CS_NONE;
                    next_st.oe_b      = 1'b1;
                    next_st.eb_b      = eba_pkg::EB_NONE;
                    next_st.dout_oe_b = 1'b1;
                    next_st.bclk      = 1'b0;
                    next_st.rsp_valid = 1'b1;
                    next_st.rsp_err   = 1'b1;
                    next_st.busy      = 1'b0;
                    next_st.fsm       = eba_pkg::S_IDLE;
                end else if (done) begin
                    if (st.rw) begin
                        if (!st.cfg.port_width_select) begin
                            next_st.rdata = data_s;
                        end else if (st.half) begin
                            next_st.rdata[31:16] = data_s[15:0];
                        end else begin
                            next_st.rdata[15:0] = data_s[15:0];
                        end
                    end
                    next_st.cs_b      = eba_pkg::CS_NONE;
                    next_st.oe_b      = 1'b1;
                    next_st.eb_b      = eba_pkg::EB_NONE;
                    next_st.dout_oe_b = 1'b1;
                    next_st.bclk      = 1'b0;
                    next_st.cnt       = 4'h0;
                    next_st.fsm       = eba_pkg::S_TRAIL;
                end
            end
            eba_pkg::S_TRAIL: begin
                // Negate delay keeps back-to-back cycles apart
                if (st.cnt >= st.cfg.select_negate_delay) begin
                    if (second) begin
                        next_st.half = 1'b1;
                        next_st.addr = st.addr + eba_pkg::HALF_STEP;
                        next_st.dout = {16'h0000, st.dout[31:16]};
                        next_st.cnt  = 4'h0;
                        next_st.fsm  = eba_pkg::S_LEAD;
                    end else begin
                        next_st.rsp_valid = 1'b1;
                        next_st.busy      = 1'b0;
                        next_st.fsm       = eba_pkg::S_IDLE;
                    end
                end else begin
                    next_st.cnt = st.cnt + 4'h1;
                end
            end
            default: begin
                next_st.fsm = eba_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st           <= '0;
            st.fsm       <= eba_pkg::S_IDLE;
            st.cs_b      <= eba_pkg::CS_NONE;
            st.rw        <= 1'b1;
            st.oe_b      <= 1'b1;
            st.eb_b      <= eba_pkg::EB_NONE;
            st.lba_b     <= 1'b1;
            st.dout_oe_b <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Falling-edge stage for address, select and direction
    always_ff @(negedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ext_addr_o <= '0;
            ext_cs_b_o <= eba_pkg::CS_NONE;
            ext_rw_o   <= 1'b1;
        end else begin
            ext_addr_o <= st.addr;
            ext_cs_b_o <= st.cs_b;
            ext_rw_o   <= st.rw;
        end
    end

    always_comb begin
        busy_o               = st.busy;
        rsp_valid_o          = st.rsp_valid;
        rsp_err_o            = st.rsp_err;
        rsp_rdata_o          = st.rdata;
        ext_data_o           = st.dout;
        ext_data_oe_b_o      = st.dout_oe_b;
        ext_oe_b_o           = st.oe_b;
        byte_lane_enable_b_o = st.eb_b;
        burst_addr_load_b_o  = st.lba_b;
        burst_clk_o          = st.bclk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    property p_timeout;
        (st.fsm == eba_pkg::S_ACCESS) && timed_out
        |=> st.rsp_valid && st.rsp_err && (st.cs_b == eba_pkg::CS_NONE) && (st.fsm == eba_pkg::S_IDLE);
    endproperty
    a_timeout: assert property (p_timeout) else $error("time-out did not end the cycle with error");

    property p_tick_bound;
        (st.fsm == eba_pkg::S_ACCESS) && (st.edge_mode || st.level_mode) |-> (st.tick < 11'(TIMEOUT));
    endproperty
    a_tick_bound: assert property (p_tick_bound) else $error("access outlived the time-out");

    property p_half_step;
        $rose(st.half) |-> (st.addr == $past(st.addr) + eba_pkg::HALF_STEP) && (st.fsm == eba_pkg::S_LEAD);
    endproperty
    a_half_step: assert property (p_half_step) else $error("second half not at address plus two");

    property p_edge_sel;
        st.edge_mode && st.busy |-> (st.req.sel == eba_pkg::EDGE_SEL) && !st.level_mode
                                    && (st.cfg.wait_state_count == eba_pkg::EDGE_WSC);
    endproperty
    a_edge_sel: assert property (p_edge_sel) else $error("edge mode on a wrong select");

    property p_level_sel;
        st.level_mode && st.busy |-> (st.req.sel != eba_pkg::SHARE_SEL) && !st.cfg.sync_mode
                                     && (st.cfg.wait_state_count > 6'h01);
    endproperty
    a_level_sel: assert property (p_level_sel) else $error("level mode on a wrong select");

    property p_blank;
        (st.fsm == eba_pkg::S_ACCESS) && st.level_mode && (st.tick == 11'h000)
        |=> (st.fsm == eba_pkg::S_ACCESS) ##1 (st.fsm == eba_pkg::S_ACCESS);
    endproperty
    a_blank: assert property (p_blank) else $error("acknowledge seen inside the blanking time");

    property p_stall;
        (st.fsm == eba_pkg::S_ACCESS) && st.level_mode && !blanked && !ack_s && !timed_out
        |=> (st.fsm == eba_pkg::S_ACCESS) && $stable(st.wait_cnt);
    endproperty
    a_stall: assert property (p_stall) else $error("low acknowledge did not stall the access");

    property p_edge_end;
        (st.fsm == eba_pkg::S_ACCESS) && st.edge_mode && ack_rise
        |=> (st.fsm == eba_pkg::S_TRAIL) && (st.cs_b == eba_pkg::CS_NONE);
    endproperty
    a_edge_end: assert property (p_edge_end) else $error("acknowledge rise did not end the access");

    property p_bclk;
        $rose(st.bclk) |=> !st.bclk ##1 !$fell(st.bclk);
    endproperty
    a_bclk: assert property (p_bclk) else $error("burst clock period too short");

    property p_pins_fall;
        $changed(st.cs_b) |=> (ext_cs_b_o == $past(st.cs_b));
    endproperty
    a_pins_fall: assert property (p_pins_fall) else $error("select pins not moved on the falling edge");

endmodule // eba_ctrl

`default_nettype wire

/* hw/eba_pkg.sv */
// Constants and types shared by the external bus acknowledge controller
`default_nettype none

package eba_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TIMEOUT_CYC   = 1024;
    localparam int BCLK_MIN_NS   = 15;
    localparam int BCLK_MIN_CYC  = (BCLK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BCLK_HALF_CYC = (BCLK_MIN_CYC + 1) / 2;
    localparam int BLANK_MIN     = 2;
    localparam int BLANK_MAX     = 5;
    localparam int SYNC_STAGES   = 2;

    ////////////////////////////////////////////////////////////////////////
    // Selects, fields and reset values
    localparam int       NUM_CS    = 6;
    localparam int       ADDR_W    = 25;
    localparam int       DATA_W    = 32;
    localparam bit [2:0] EDGE_SEL  = 3'h5;
    localparam bit [2:0] SHARE_SEL = 3'h4;
    localparam bit [5:0] EDGE_WSC  = 6'h3F;
    localparam bit [24:0] HALF_STEP = 25'h0000002;
    localparam bit [3:0] EB_HALF   = 4'hC;
    localparam bit [3:0] EB_WORD   = 4'h0;
    localparam bit [3:0] EB_NONE   = 4'hF;
    localparam bit [5:0] CS_NONE   = 6'h3F;

    typedef enum logic [3:0] {
        S_IDLE   = 4'h1,
        S_LEAD   = 4'h2,
        S_ACCESS = 4'h4,
        S_TRAIL  = 4'h8
    } eba_state_e_t;

    typedef struct packed {
        logic [5:0] wait_state_count;
        logic [3:0] select_assert_delay;
        logic [3:0] select_negate_delay;
        logic [3:0] read_strobe_assert_delay;
        logic [3:0] read_strobe_negate_delay;
        logic       ack_level_enable;
        logic [1:0] ack_blanking_time;
        logic       port_width_select;
        logic       sync_mode;
        logic       byte_lane_control;
    } eba_cfg_t;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic              word;
        logic [2:0]        sel;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } eba_req_t;

    typedef struct packed {
        eba_state_e_t      fsm;
        eba_req_t          req;
        eba_cfg_t          cfg;
        logic              edge_mode;
        logic              level_mode;
        logic              half;
        logic [3:0]        cnt;
        logic [10:0]       tick;
        logic [5:0]        wait_cnt;
        logic              ack_d;
        logic [ADDR_W-1:0] addr;
        logic [NUM_CS-1:0] cs_b;
        logic              rw;
        logic              oe_b;
        logic [3:0]        eb_b;
        logic              lba_b;
        logic              bclk;
        logic [DATA_W-1:0] dout;
        logic              dout_oe_b;
        logic [DATA_W-1:0] rdata;
        logic              rsp_valid;
        logic              rsp_err;
        logic              busy;
    } eba_state_t;

endpackage

`default_nettype wire

/* hw/eba_sync.sv */
// Two flip-flop synchroniser for pin inputs
`default_nettype none

module eba_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta;

    // The first stage feeds only the second stage
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta <= '0;
            q_o  <= '0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end

endmodule // eba_sync

`default_nettype wire

/* sim/eba_ext_model.sv */
// External asynchronous device model answering the external bus
`default_nettype none

module eba_ext_model (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [5:0]  cs_b_i,
    input  wire logic [24:0] addr_i,
    input  wire logic        idle_i,
    input  wire logic [7:0]  dly_i,
    output logic             ack_o,
    output logic [31:0]      data_o
);
    ////////////////////////////////////////////////////////////////////////
    logic       sel;
    logic [7:0] cnt;
    logic [31:0] last;

    function automatic logic [31:0] dval(input logic [24:0] a);
        return {a[15:0] ^ 16'h3C00, a[15:0] ^ 16'h1000};
    endfunction

    assign sel = (cs_b_i !== 6'h3F);
    // Released data bus shows the inverse of the last value, never a stale copy
    assign data_o = sel ? dval(addr_i) : ~last;
    // 8'hFF means the device never answers; at deselect ack follows idle_i, which is held low for a fresh edge
    assign ack_o = sel ? (cnt >= dly_i && dly_i != 8'hFF) : idle_i;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt  <= 8'h00;
            last <= 32'h00000000;
        end else if (sel) begin
            cnt  <= (cnt == 8'hFE) ? cnt : cnt + 8'h01;
            last <= data_o;
        end else begin
            cnt <= 8'h00;
        end
    end
endmodule // eba_ext_model

`default_nettype wire

/* sim/tb_eba_ctrl.sv */
// Self-checking testbench for the external bus acknowledge controller
`default_nettype none

module tb_eba_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TO = 16;
    logic clk_i = 1'b0, rst_b_i = 1'b0, ack_edge_global_bit = 1'b0, idle = 1'b1;
    eba_pkg::eba_req_t req = '0;
    eba_pkg::eba_cfg_t cfg = '0;
    logic busy, rv, re, xoe, rw, oe, burst_addr_load, bclk, ack, err, bad_bclk = 1'b0;
    logic bclk_d = 1'b0, oe_seen = 1'b0, lba_seen = 1'b0, wd_seen = 1'b0, bad_dir = 1'b0;
    logic [15:0] wd0, wd1;
    logic [31:0] rd, xdo, xdi, rdat;
    logic [24:0] xa, last_a;
    logic [5:0] cs;
    logic [3:0] eb;
    logic [7:0] dly = 8'h00;
    int num_errors = 0, checks = 0, lat, n, since = 9, rises = 0;

    always #5 clk_i = ~clk_i;

    eba_ctrl #(.TIMEOUT(TO)) dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req), .cfg_i(cfg),
        .ack_edge_global_bit_i(ack_edge_global_bit), .busy_o(busy), .rsp_valid_o(rv), .rsp_err_o(re), .rsp_rdata_o(rd),
        .transfer_ack_input_i(ack), .ext_data_i(xdi), .ext_data_o(xdo), .ext_data_oe_b_o(xoe),
        .ext_addr_o(xa), .ext_cs_b_o(cs), .ext_rw_o(rw), .ext_oe_b_o(oe), .byte_lane_enable_b_o(eb),
        .burst_addr_load_b_o(burst_addr_load), .burst_clk_o(bclk));
    eba_ext_model mdl_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs), .addr_i(xa), .idle_i(idle),
        .dly_i(dly), .ack_o(ack), .data_o(xdi));

    ////////////////////////////////////////////////////////////////////////
    always @(negedge clk_i) begin
        if (cs !== 6'h3F) last_a <= xa;
        if (oe === 1'b0) oe_seen <= 1'b1;
        if (burst_addr_load === 1'b0) lba_seen <= 1'b1;
        if (xoe === 1'b0) begin
            if (!wd_seen) wd0 <= xdo[15:0];
            wd_seen <= 1'b1;
            wd1 <= xdo[15:0];
        end
        // A driven data bus needs a write cycle, upper lanes off and the read strobe quiet
        if ((xoe === 1'b0 && (rw !== 1'b0 || eb !== 4'hC || oe !== 1'b1)) || (oe === 1'b0 && rw !== 1'b1))
            bad_dir <= 1'b1;
    end
    // Two burst clock rises closer than two cycles would break the minimum period
    always @(posedge clk_i) begin
        since <= since + 1;
        bclk_d <= bclk;
        if (bclk === 1'b1 && bclk_d === 1'b0) begin
            rises <= rises + 1;
            since <= 1;
            if (since < 2) bad_bclk <= 1'b1;
        end
    end

    function automatic logic [31:0] dval(input logic [24:0] a);
        return {a[15:0] ^ 16'h3C00, a[15:0] ^ 16'h1000};
    endfunction

    // Low half of the model's word, as one half-width access returns it
    function automatic logic [15:0] lo16(input logic [24:0] a);
        logic [31:0] v;
        v = dval(a);
        return v[15:0];
    endfunction

    task automatic finish_test;
        if (num_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask

    // One request, read or write as req.write gives; lat counts cycles from the taking edge to the response
    task automatic run(input logic [2:0] sel, input logic word, input logic [24:0] a);
        @(negedge clk_i);
        req.valid = 1'b1;
        req.sel = sel;
        req.word = word;
        req.addr = a;
        @(negedge clk_i);
        req.valid = 1'b0;
        lat = 1;
        while (rv !== 1'b1 && lat < 300) begin
            @(negedge clk_i);
            lat++;
        end
        err = re;
        rdat = rd;
        if (lat >= 300) chk("response", 32'h0, 32'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_level;
        cfg = '0;
        cfg.wait_state_count = 6'h02;
        cfg.ack_level_enable = 1'b1;
        cfg.ack_blanking_time = 2'h1;
        run(3'h1, 1'b0, 25'h0000100);
        chk("level err", err, 0);
        chk("level data", rdat, dval(25'h0000100));
        chk("busy at answer", busy, 0);
        chk("read strobe", oe_seen, 1);
        n = lat;
        dly = 8'h0C;
        run(3'h1, 1'b0, 25'h0000104);
        chk("stall err", err, 0);
        chk("stall longer", lat > n + 4, 1);
        dly = 8'hFF;
        run(3'h1, 1'b0, 25'h0000108);
        chk("level timeout", err, 1);
        @(negedge clk_i);
        chk("cs after timeout", cs, 6'h3F);
        ack_edge_global_bit = 1'b1;
        run(3'h1, 1'b0, 25'h000010C);
        chk("global bit blocks level", err, 0);
        ack_edge_global_bit = 1'b0;
        run(3'h4, 1'b0, 25'h0000110);
        chk("select four ignores ack", err, 0);
        chk("no burst load", lba_seen, 0);
        cfg.sync_mode = 1'b1;
        rises = 0;
        run(3'h1, 1'b0, 25'h0000114);
        chk("sync ignores ack", err, 0);
        chk("burst clock runs", rises > 0, 1);
        chk("burst clock period", bad_bclk, 0);
        chk("burst load", lba_seen, 1);
        cfg.sync_mode = 1'b0;
        cfg.port_width_select = 1'b1;
        dly = 8'h00;
        run(3'h2, 1'b1, 25'h0000200);
        chk("split data", rdat, {lo16(25'h0000202), lo16(25'h0000200)});
        chk("second half address", last_a, 25'h0000202);
        req.write = 1'b1;
        req.wdata = 32'hA5C31E2D;
        run(3'h2, 1'b1, 25'h0000220);
        req.write = 1'b0;
        chk("write err", err, 0);
        chk("write low half", wd0, 16'h1E2D);
        chk("write high half", wd1, 16'hA5C3);
        chk("write address", last_a, 25'h0000222);
        chk("strobe directions", bad_dir, 0);
    endtask

    task automatic t_edge;
        cfg = '0;
        cfg.wait_state_count = 6'h3F;
        cfg.select_assert_delay = 4'h1;
        ack_edge_global_bit = 1'b1;
        idle = 1'b0;
        dly = 8'h04;
        run(3'h5, 1'b0, 25'h0000300);
        chk("edge err", err, 0);
        chk("edge data", rdat, dval(25'h0000300));
        cfg.port_width_select = 1'b1;
        run(3'h5, 1'b1, 25'h0000400);
        chk("edge split err", err, 0);
        chk("edge split data", rdat, {lo16(25'h0000402), lo16(25'h0000400)});
        dly = 8'hFF;
        run(3'h5, 1'b0, 25'h0000500);
        chk("edge timeout", err, 1);
        chk("timeout delay", lat >= TO && lat <= TO + 12, 1);
        run(3'h3, 1'b0, 25'h0000504);
        chk("edge only on five", err, 0);
        cfg.select_assert_delay = 4'h0;
        run(3'h5, 1'b0, 25'h0000508);
        chk("edge needs delay", err, 0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #200us;
        num_errors++;
        finish_test();
    end

    initial begin
        repeat (12) @(negedge clk_i);
        chk("reset pins", {19'h0, cs, eb, oe, busy, rv}, {19'h0, 6'h3F, 4'hF, 3'h4});
        rst_b_i = 1'b1;
        t_level();
        t_edge();
        finish_test();
    end
endmodule // tb_eba_ctrl

`default_nettype wire
